// [design/flash_erase_command_control.sv]
// Flash erase command control: erase command, mass-erase arming,
// page address and emulator clock disable registers.
// Assumes SFR writes and config accesses from the MPU on sys_clk and
// a debug-port enable level arriving from outside the clock domain.
`timescale 1ns/10ps
module flash_erase_command_control
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  sfr_we,
    input  wire logic [7:0]            sfr_addr,
    input  wire logic [7:0]            sfr_wdata,
    input  wire logic                  cfg_we,
    input  wire logic                  cfg_re,
    input  wire logic [15:0]           cfg_addr,
    input  wire logic [7:0]            cfg_wdata,
    output logic      [7:0]            cfg_rdata,
    input  wire logic                  debug_port,
    input  wire logic                  flash_busy,
    output logic                       flash_page_erase,
    output logic                       flash_mass_erase,
    output logic      [flash_erase_pkg::PAGE_ADDR_W-1:0] erase_page_address,
    output logic                       erase_busy,
    output logic                       emulator_clock_stop,
    output logic                       ice_access_en
);
    import flash_erase_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]             erase_cmd_reg;
    logic                   mass_arm_reg;
    logic [PAGE_ADDR_W-1:0] page_addr_reg;
    logic                   page_valid_reg;
    logic                   emu_clk_off_reg;
    logic [7:0]             rdata_reg;
    logic                   ice_en_reg;
    logic [2:0]             dbg_sync_reg;
    logic                   debug_en_reg;
    logic                   page_strobe;
    logic                   mass_strobe;
    logic                   seq_idle;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire cmd_hit  = sfr_we && (sfr_addr == ERASE_CMD_OFFSET);
    wire arm_hit  = sfr_we && (sfr_addr == MASS_ARM_OFFSET);
    wire page_hit = sfr_we && (sfr_addr == PAGE_ADDR_OFFSET);
    wire emu_wr   = cfg_we && (cfg_addr == EMU_CTRL_OFFSET);
    wire emu_rd   = cfg_re && (cfg_addr == EMU_CTRL_OFFSET);
    wire is_mass  = (erase_cmd_reg == MASS_ERASE_CODE);
    wire is_page  = (erase_cmd_reg == PAGE_ERASE_CODE);

    // Emulator clock off also blocks mass erase: no debug access, no erase
    wire mass_go  = is_mass && mass_arm_reg && debug_en_reg && !emu_clk_off_reg && seq_idle;
    wire page_go  = is_page && page_valid_reg && seq_idle;

    wire [7:0] rdata_next = emu_rd ? {2'b00, emu_clk_off_reg, 5'b00000} : RDATA_RESET;

    // ----------------------------------------------------------------
    // Debug port synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dbg_sync_reg <= 3'b000;
            debug_en_reg <= 1'b0;
        end else begin
            dbg_sync_reg <= {dbg_sync_reg[1:0], debug_port};
            if (dbg_sync_reg[1] == dbg_sync_reg[2]) begin
                debug_en_reg <= dbg_sync_reg[2];
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Command lives one cycle only, so unknown codes leave no trace
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            erase_cmd_reg <= ERASE_CMD_RESET;
        end else begin
            erase_cmd_reg <= cmd_hit ? sfr_wdata : ERASE_CMD_RESET;
        end
    end

    // Software arm write wins over the hardware clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mass_arm_reg <= MASS_ARM_RESET;
        end else if (arm_hit) begin
            mass_arm_reg <= sfr_wdata[MASS_ARM_BIT];
        end else if (mass_go) begin
            mass_arm_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            page_addr_reg  <= PAGE_ADDR_RESET;
            page_valid_reg <= 1'b0;
        end else if (page_hit) begin
            page_addr_reg  <= sfr_wdata[PAGE_ADDR_LSB +: PAGE_ADDR_W];
            page_valid_reg <= 1'b1;
        end else if (page_go) begin
            page_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            emu_clk_off_reg <= EMU_CLK_OFF_RESET;
            rdata_reg       <= RDATA_RESET;
            ice_en_reg      <= 1'b0;
        end else begin
            if (emu_wr) begin
                emu_clk_off_reg <= cfg_wdata[EMU_CLK_OFF_BIT];
            end
            rdata_reg  <= rdata_next;
            ice_en_reg <= debug_en_reg && !emu_clk_off_reg;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer and outputs
    // ----------------------------------------------------------------
    erase_sequencer u_seq (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .start_page      (page_go),
        .start_mass      (mass_go),
        .flash_busy      (flash_busy),
        .page_strobe_reg (page_strobe),
        .mass_strobe_reg (mass_strobe),
        .seq_idle_reg    (seq_idle)
    );

    assign flash_page_erase    = page_strobe;
    assign flash_mass_erase    = mass_strobe;
    assign erase_busy          = !seq_idle;
    assign erase_page_address  = page_addr_reg;
    assign emulator_clock_stop = emu_clk_off_reg;
    assign ice_access_en       = ice_en_reg;
    assign cfg_rdata           = rdata_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_mass_write;
        sfr_we && (sfr_addr == ERASE_CMD_OFFSET) && (sfr_wdata == MASS_ERASE_CODE);
    endsequence

    sequence s_mass_ready;
        mass_arm_reg && debug_en_reg && !emu_clk_off_reg && seq_idle && !arm_hit;
    endsequence

    property p_mass_start;
        @(posedge sys_clk) disable iff (rst)
        s_mass_write ##1 s_mass_ready |=> flash_mass_erase && !flash_page_erase;
    endproperty
    a_mass_start: assert property (p_mass_start) else $error("mass erase not started");

    property p_mass_gated;
        @(posedge sys_clk) disable iff (rst)
        $rose(flash_mass_erase) |-> $past(mass_arm_reg) && $past(debug_en_reg) && $past(is_mass);
    endproperty
    a_mass_gated: assert property (p_mass_gated) else $error("mass erase without arm or debug port");

    property p_unknown_code;
        @(posedge sys_clk) disable iff (rst)
        !is_mass && !is_page && !arm_hit && !page_hit && seq_idle
            |=> !flash_mass_erase && !flash_page_erase && $stable(mass_arm_reg) && $stable(page_valid_reg);
    endproperty
    a_unknown_code: assert property (p_unknown_code) else $error("unknown code changed erase state");

    property p_page_start;
        @(posedge sys_clk) disable iff (rst)
        page_go && !page_hit |=> flash_page_erase && (erase_page_address == $past(page_addr_reg));
    endproperty
    a_page_start: assert property (p_page_start) else $error("page erase not started on chosen page");

    property p_cmd_one_cycle;
        @(posedge sys_clk) disable iff (rst)
        !cmd_hit |=> erase_cmd_reg == ERASE_CMD_RESET;
    endproperty
    a_cmd_one_cycle: assert property (p_cmd_one_cycle) else $error("command register did not return to zero");

    property p_arm_write;
        @(posedge sys_clk) disable iff (rst)
        arm_hit |=> mass_arm_reg == $past(sfr_wdata[MASS_ARM_BIT]);
    endproperty
    a_arm_write: assert property (p_arm_write) else $error("arm bit did not follow write");

    property p_eck_stop;
        @(posedge sys_clk) disable iff (rst)
        emu_wr |=> (emulator_clock_stop == $past(cfg_wdata[EMU_CLK_OFF_BIT]))
            ##1 (!ice_access_en || !$past(emulator_clock_stop));
    endproperty
    a_eck_stop: assert property (p_eck_stop) else $error("emulator clock disable not applied");

    property p_ice_refused;
        @(posedge sys_clk) disable iff (rst)
        emu_clk_off_reg |-> !mass_go ##1 !ice_access_en;
    endproperty
    a_ice_refused: assert property (p_ice_refused) else $error("emulator access while clock off");

    property p_page_rewrite;
        @(posedge sys_clk) disable iff (rst)
        page_go && !page_hit |=> !page_valid_reg ##1 (!flash_page_erase)[*2];
    endproperty
    a_page_rewrite: assert property (p_page_rewrite) else $error("page address reused without rewrite");

    property p_arm_cleared;
        @(posedge sys_clk) disable iff (rst)
        mass_go && !arm_hit |=> !mass_arm_reg;
    endproperty
    a_arm_cleared: assert property (p_arm_cleared) else $error("arm not cleared after mass erase");

endmodule : flash_erase_command_control

// [design/flash_erase_pkg.sv]
// Constants and types for the flash erase command control block.
// Assumes an 8-bit special-function register write port and a 16-bit
// configuration register port, both on sys_clk.
package flash_erase_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  ERASE_CMD_OFFSET  = 8'h94;
    localparam logic [7:0]  MASS_ARM_OFFSET   = 8'hB2;
    localparam logic [7:0]  PAGE_ADDR_OFFSET  = 8'hB7;
    localparam logic [15:0] EMU_CTRL_OFFSET   = 16'h2005;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          EMU_CLK_OFF_BIT   = 5;
    localparam int          MASS_ARM_BIT      = 1;
    localparam int          PAGE_ADDR_LSB     = 1;
    localparam int          PAGE_ADDR_W       = 7;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  MASS_ERASE_CODE   = 8'hAA;
    localparam logic [7:0]  PAGE_ERASE_CODE   = 8'h55;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0]  ERASE_CMD_RESET   = 8'h00;
    localparam logic [6:0]  PAGE_ADDR_RESET   = 7'h00;
    localparam logic        MASS_ARM_RESET    = 1'b0;
    localparam logic        EMU_CLK_OFF_RESET = 1'b0;
    localparam logic [7:0]  RDATA_RESET       = 8'h00;

    // ----------------------------------------------------------------
    // Erase sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b001,
        SEQ_ISSUE = 3'b010,
        SEQ_WAIT  = 3'b100
    } seq_state_e;

endpackage : flash_erase_pkg

// [design/erase_sequencer.sv]
// Erase sequencer: issues one-cycle erase strobes to the flash array.
// Assumes flash_busy comes from flash logic on sys_clk and rises the
// cycle after a strobe, staying high until the erase is done.
`timescale 1ns/10ps
module erase_sequencer
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic start_page,
    input  wire logic start_mass,
    input  wire logic flash_busy,
    output logic      page_strobe_reg,
    output logic      mass_strobe_reg,
    output logic      seq_idle_reg
);
    import flash_erase_pkg::*;

    seq_state_e state_reg;
    seq_state_e state_next;
    wire        go = start_page || start_mass;

    // ----------------------------------------------------------------
    // State machine
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SEQ_IDLE:  state_next = go ? SEQ_ISSUE : SEQ_IDLE;
            SEQ_ISSUE: state_next = SEQ_WAIT;
            SEQ_WAIT:  state_next = flash_busy ? SEQ_WAIT : SEQ_IDLE;
            default:   state_next = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg       <= SEQ_IDLE;
            page_strobe_reg <= 1'b0;
            mass_strobe_reg <= 1'b0;
            seq_idle_reg    <= 1'b1;
        end else begin
            state_reg       <= state_next;
            page_strobe_reg <= (state_reg == SEQ_IDLE) && start_page && !start_mass;
            mass_strobe_reg <= (state_reg == SEQ_IDLE) && start_mass;
            seq_idle_reg    <= (state_next == SEQ_IDLE);
        end
    end

endmodule : erase_sequencer

// [sim/flash_array_model.sv]
// Behavioural flash array facing the erase control block.
// Assumes one-cycle erase strobes on sys_clk; erase length comes from the bench.
`timescale 1ns/10ps
module flash_array_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       page_erase,
    input  wire logic       mass_erase,
    input  wire logic [6:0] page_address,
    input  wire logic [7:0] busy_len,
    output logic            flash_busy,
    output int              page_cnt,
    output int              mass_cnt,
    output logic [6:0]      last_page
);
    // ------------------------------------------------------------
    // Erase timing
    // ------------------------------------------------------------
    logic [7:0] left_reg;
    // Busy rises the cycle after a strobe, never later
    assign flash_busy = (left_reg != 8'h00);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            left_reg <= 8'h00;
            page_cnt <= 0;
            mass_cnt <= 0;
            last_page <= 7'h00;
        end else if (page_erase || mass_erase) begin
            left_reg <= busy_len;
            page_cnt <= page_cnt + int'(page_erase);
            mass_cnt <= mass_cnt + int'(mass_erase);
            last_page <= page_erase ? page_address : last_page;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end
endmodule : flash_array_model

// [sim/test_flash_erase_command_control.sv]
// Self-checking bench for the flash erase command control block.
// Assumes the flash array model beside it; stimulus on falling edges.
`timescale 1ns/10ps
module test_flash_erase_command_control;
    import flash_erase_pkg::*;
    logic sys_clk = 0, rst = 1, sfr_we = 0, cfg_we = 0, cfg_re = 0, debug_port = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, cfg_wdata = 8'h00, cfg_rdata, busy_len = 8'h04;
    logic [15:0] cfg_addr = 16'h0000;
    logic flash_busy, flash_page_erase, flash_mass_erase, erase_busy, emulator_clock_stop, ice_access_en;
    logic [6:0] erase_page_address, last_page, p;
    logic [7:0] v;
    logic a, d, e, armed = 0;
    logic [31:0] seed = 32'd43;
    int page_cnt, mass_cnt, epage = 0, emass = 0, failures = 0, checked = 0;
    // ------------------------------------------------------------
    // Instances and clock
    // ------------------------------------------------------------
    flash_erase_command_control dut_u (.sys_clk(sys_clk), .rst(rst), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .cfg_we(cfg_we), .cfg_re(cfg_re), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .debug_port(debug_port), .flash_busy(flash_busy),
        .flash_page_erase(flash_page_erase), .flash_mass_erase(flash_mass_erase),
        .erase_page_address(erase_page_address), .erase_busy(erase_busy),
        .emulator_clock_stop(emulator_clock_stop), .ice_access_en(ice_access_en));
    flash_array_model flash_u (.sys_clk(sys_clk), .rst(rst), .page_erase(flash_page_erase),
        .mass_erase(flash_mass_erase), .page_address(erase_page_address), .busy_len(busy_len),
        .flash_busy(flash_busy), .page_cnt(page_cnt), .mass_cnt(mass_cnt), .last_page(last_page));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Mass erase needs arming, debug port on, emulator clock running
    function automatic logic mass_ok(input logic arm, input logic dbg, input logic eck);
        return arm & dbg & ~eck;
    endfunction : mass_ok
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    task automatic sfr_wr(input logic [7:0] ad, input logic [7:0] da);
        @(negedge sys_clk);
        sfr_we = 1;
        sfr_addr = ad;
        sfr_wdata = da;
        @(negedge sys_clk);
        sfr_we = 0;
    endtask : sfr_wr
    task automatic cfg_acc(input logic wr, input logic [15:0] ad, input logic [7:0] da, output logic [7:0] rd);
        @(negedge sys_clk);
        cfg_we = wr;
        cfg_re = ~wr;
        cfg_addr = ad;
        cfg_wdata = da;
        @(negedge sys_clk);
        cfg_we = 0;
        cfg_re = 0;
        rd = cfg_rdata;
    endtask : cfg_acc
    // Bounded wait so a stuck sequencer cannot hang the run
    task automatic wait_idle();
        repeat (4) @(negedge sys_clk);
        for (int n = 0; n < 300 && erase_busy !== 1'b0; n++) @(negedge sys_clk);
        check(erase_busy, 0);
    endtask : wait_idle
    task automatic tally_and_finish();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk) rst = 0;
        check({flash_page_erase, flash_mass_erase, emulator_clock_stop}, 0);
        check(erase_page_address, 0);
        cfg_acc(0, EMU_CTRL_OFFSET, 8'h00, v);
        check(v, 0);
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            p = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'(rnd());
            busy_len = 8'h01 + {4'h0, 4'(rnd())};
            sfr_wr(PAGE_ADDR_OFFSET, {p, 1'b0});
            sfr_wr(ERASE_CMD_OFFSET, PAGE_ERASE_CODE);
            wait_idle();
            epage++;
            check(page_cnt, epage);
            check(last_page, p);
        end
        sfr_wr(ERASE_CMD_OFFSET, PAGE_ERASE_CODE);
        wait_idle();
        check(page_cnt, epage);
        busy_len = 8'h28;
        sfr_wr(PAGE_ADDR_OFFSET, 8'h0A);
        sfr_wr(ERASE_CMD_OFFSET, PAGE_ERASE_CODE);
        sfr_wr(PAGE_ADDR_OFFSET, 8'h14);
        sfr_wr(ERASE_CMD_OFFSET, PAGE_ERASE_CODE);
        wait_idle();
        epage++;
        check(page_cnt, epage);
        check(last_page, 7'h05);
        $display("page test done");
        busy_len = 8'h03;
        for (int i = 0; i < 16; i++) begin
            v = 8'(rnd());
            {e, d, a} = (i < 2) ? 3'b011 : v[2:0];
            debug_port = d;
            // Power-up settling time scaled down; the run is far shorter than a second
            cfg_acc(1, EMU_CTRL_OFFSET, {2'b00, e, 5'h00}, v);
            if (a) sfr_wr(MASS_ARM_OFFSET, 8'h02);
            armed = armed | a;
            repeat (6) @(negedge sys_clk);
            check(emulator_clock_stop, e);
            check(ice_access_en, d & ~e);
            cfg_acc(0, EMU_CTRL_OFFSET, 8'h00, v);
            check(v, {2'b00, e, 5'h00});
            sfr_wr(ERASE_CMD_OFFSET, MASS_ERASE_CODE);
            wait_idle();
            if (mass_ok(armed, d, e)) emass++;
            if (mass_ok(armed, d, e)) armed = 0;
            check(mass_cnt, emass);
        end
        sfr_wr(ERASE_CMD_OFFSET, MASS_ERASE_CODE);
        wait_idle();
        check(mass_cnt, emass);
        $display("mass test done");
        debug_port = 1;
        cfg_acc(1, 16'h2004, 8'hFF, v);
        cfg_acc(0, 16'h2004, 8'h00, v);
        check(v, 0);
        cfg_acc(1, EMU_CTRL_OFFSET, 8'h00, v);
        sfr_wr(PAGE_ADDR_OFFSET, 8'h42);
        sfr_wr(MASS_ARM_OFFSET, 8'h02);
        for (int i = 0; i < 8; i++) begin
            v = 8'(rnd());
            if (v == MASS_ERASE_CODE || v == PAGE_ERASE_CODE) v = 8'h00;
            sfr_wr(ERASE_CMD_OFFSET, v);
            repeat (4) @(negedge sys_clk);
            check(page_cnt, epage);
            check(mass_cnt, emass);
        end
        sfr_wr(ERASE_CMD_OFFSET, PAGE_ERASE_CODE);
        wait_idle();
        sfr_wr(ERASE_CMD_OFFSET, MASS_ERASE_CODE);
        wait_idle();
        check(page_cnt, epage + 1);
        check(mass_cnt, emass + 1);
        $display("command code test done");
        tally_and_finish();
    end
endmodule : test_flash_erase_command_control
